//--- qdac_pkg.sv
// Shared constants and types for the quad converter serial load control.
// Assumes one 100 MHz clock domain; all link pins are sampled, not clocked on.
package qdac_pkg;

  localparam int CODE_W = 16;
  localparam int NCH = 4;
  localparam int FRAME_BITS = 24;
  localparam int NPINS = 7;

  // Command field encodings
  localparam logic [3:0] CMD_WR_IN = 4'h1;
  localparam logic [3:0] CMD_UPD = 4'h2;
  localparam logic [3:0] CMD_WR_UPD = 4'h3;
  localparam logic [3:0] CMD_SOFT_RST = 4'h6;
  localparam logic [3:0] CMD_DAISY = 4'h8;
  localparam logic [3:0] CMD_READBACK = 4'h9;

  // Output levels
  localparam logic [CODE_W-1:0] ZERO_SCALE = 16'h0000;
  localparam logic [CODE_W-1:0] MID_SCALE = 16'h8000;

  // Sampled pin positions and their values while resetn is low
  localparam int PIN_SCLK = 0;
  localparam int PIN_SYNC = 1;
  localparam int PIN_SIN = 2;
  localparam int PIN_LOAD = 3;
  localparam int PIN_RST = 4;
  localparam int PIN_RSEL = 5;
  localparam int PIN_SPAN = 6;
  localparam logic [NPINS-1:0] PIN_RESET_VAL = 7'h0b;
  localparam logic [1:0] SETTLE_MAX = 2'h3;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DAC_BASE = 8'h10;
  localparam logic [7:0] REG_INPUT_BASE = 8'h20;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_SYNC_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam int STAT_INIT_BIT = 0;
  localparam int STAT_RSTPIN_BIT = 1;
  localparam int STAT_OVR_BIT = 2;
  localparam int STAT_DAISY_BIT = 3;
  localparam int STAT_RB_BIT = 4;
  localparam int STAT_NEW_LSB = 8;

  typedef struct packed {
    logic [3:0] cmd;
    logic [NCH-1:0] chan;
    logic [CODE_W-1:0] code;
  } qdac_frame_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } qdac_aphase_t;

endpackage

//--- qdac_top.sv
// Quad converter serial load control: frame capture, command FIFO, channel
// registers, load strobe, pin reset and an AHB-Lite register slave.
// Assumes the link pins are asynchronous and slower than a quarter of clock.
//
// How it works
// - Serial output bit changes after a rising shift-clock edge.
// - Load strobe pulse copies channels holding new data into converter registers.
// - Load strobe held low makes written data reach converter registers directly.
// - Strobe acts either on its own falling edge or at frame completion.
// - Span select sets the doubled span for all four outputs.
// - Data bits are sampled on falling shift-clock edges; host keeps clock slow.
// - Frame select low opens a frame of 24 falling-edge bits.
// - A 24-bit shift register collects the serial word.
// - Reset pin acts on its falling edge, independent of shift clock.
// - While reset pin is low, strobe pulses cause no transfer.
// - Reset loads input and converter registers with zero or midscale.
// - Power-up initialization waits until the reset pin is released.
// - Power-up level is zero scale or midscale from reset-level select.
// - Word is MSB first: command, channel select bits, then code.
// - Captured command executes once frame select returns high.
// - Host strobes only between frames; device then updates outputs.
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module qdac_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("qdac_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;

  assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_q != rd_q;
  assign out_data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clock) begin
    if (in_valid && in_ready) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module qdac_top #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Serial link pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic serial_in,
  output logic serial_out,
  // Control pins
  input wire logic load_strobe_n,
  input wire logic reset_pin_n,
  input wire logic reset_level_select,
  input wire logic span_select,
  // Converter side
  output logic [qdac_pkg::NCH-1:0][qdac_pkg::CODE_W-1:0] dac_code,
  output logic span_x2,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  localparam int NCH = qdac_pkg::NCH;
  localparam int NP = qdac_pkg::NPINS;

  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_IDLE = 3'b010,
    ST_EXEC = 3'b100
  } qdac_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] meta_q;
  logic [NP-1:0] pin_q;
  logic [NP-1:0] prev_q;

  assign pin_raw = {span_select, reset_level_select, reset_pin_n, load_strobe_n, serial_in, sync_n, sclk};

  for (genvar p = 0; p < NP; p++) begin : g_sync
    always_ff @(posedge clock) begin
      if (!resetn) begin
        meta_q[p] <= qdac_pkg::PIN_RESET_VAL[p];
        pin_q[p] <= qdac_pkg::PIN_RESET_VAL[p];
        prev_q[p] <= qdac_pkg::PIN_RESET_VAL[p];
      end else begin
        meta_q[p] <= pin_raw[p];
        pin_q[p] <= meta_q[p];
        prev_q[p] <= pin_q[p];
      end
    end
  end

  logic sclk_fall;
  logic sclk_rise;
  logic sync_fall;
  logic sync_rise;
  logic load_fall;
  logic rst_fall;
  logic rst_low;
  logic load_low;
  logic [qdac_pkg::CODE_W-1:0] level;

  assign sclk_fall = prev_q[qdac_pkg::PIN_SCLK] && !pin_q[qdac_pkg::PIN_SCLK];
  assign sclk_rise = !prev_q[qdac_pkg::PIN_SCLK] && pin_q[qdac_pkg::PIN_SCLK];
  assign sync_fall = prev_q[qdac_pkg::PIN_SYNC] && !pin_q[qdac_pkg::PIN_SYNC];
  assign sync_rise = !prev_q[qdac_pkg::PIN_SYNC] && pin_q[qdac_pkg::PIN_SYNC];
  assign load_fall = prev_q[qdac_pkg::PIN_LOAD] && !pin_q[qdac_pkg::PIN_LOAD];
  assign rst_fall = prev_q[qdac_pkg::PIN_RST] && !pin_q[qdac_pkg::PIN_RST];
  assign rst_low = !pin_q[qdac_pkg::PIN_RST];
  assign load_low = !pin_q[qdac_pkg::PIN_LOAD];
  assign level = pin_q[qdac_pkg::PIN_RSEL] ? qdac_pkg::MID_SCALE : qdac_pkg::ZERO_SCALE;

  // Span pin is a level; one register stage keeps the output a flop
  always_ff @(posedge clock) begin
    if (!resetn) begin
      span_x2 <= 1'b0;
    end else begin
      span_x2 <= pin_q[qdac_pkg::PIN_SPAN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame capture
  logic frame_q;
  logic [4:0] cnt_q;
  logic [qdac_pkg::FRAME_BITS-1:0] sr_q;
  logic rb_drive_q;
  logic rb_armed_q;
  logic daisy_q;
  logic [qdac_pkg::CODE_W-1:0] rb_word;
  logic push;
  logic fifo_in_ready;
  qdac_state_t state_q;

  assign push = sync_rise && frame_q && cnt_q != '0;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      frame_q <= 1'b0;
      cnt_q <= '0;
      sr_q <= '0;
      rb_drive_q <= 1'b0;
    end else if (sync_fall && state_q != ST_INIT) begin
      frame_q <= 1'b1;
      cnt_q <= '0;
      rb_drive_q <= rb_armed_q;
      if (rb_armed_q) begin
        sr_q <= {8'h00, rb_word};
      end
    end else if (sync_rise) begin
      frame_q <= 1'b0;
      rb_drive_q <= 1'b0;
    end else if (frame_q && sclk_fall && cnt_q < 5'(qdac_pkg::FRAME_BITS)) begin
      sr_q <= {sr_q[qdac_pkg::FRAME_BITS-2:0], pin_q[qdac_pkg::PIN_SIN]};
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Shifted word leaves MSB first, one bit per rising edge
  always_ff @(posedge clock) begin
    if (!resetn) begin
      serial_out <= 1'b0;
    end else if (sync_fall && state_q != ST_INIT && (daisy_q || rb_armed_q)) begin
      // First bit must stand before the first falling edge of an idle-high clock
      serial_out <= rb_armed_q ? 1'b0 : sr_q[qdac_pkg::FRAME_BITS-1];
    end else if (!(frame_q && (daisy_q || rb_drive_q))) begin
      serial_out <= 1'b0;
    end else if (sclk_rise) begin
      serial_out <= sr_q[qdac_pkg::FRAME_BITS-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command FIFO; a hold bit stalls the drain so frames queue up
  logic [31:0] ctrl_q;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [qdac_pkg::FRAME_BITS-1:0] fifo_out_data;
  qdac_pkg::qdac_frame_t cur_q;

  assign fifo_out_ready = state_q == ST_IDLE && !ctrl_q[qdac_pkg::CTRL_HOLD_BIT];

  qdac_fifo #(
    .WIDTH(qdac_pkg::FRAME_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(sr_q),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Executor
  logic [1:0] settle_q;
  logic exec;
  logic load_level;

  assign exec = state_q == ST_EXEC;
  assign load_level = (state_q == ST_INIT && settle_q == qdac_pkg::SETTLE_MAX && !rst_low) || rst_fall
    || (exec && cur_q.cmd == qdac_pkg::CMD_SOFT_RST);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= ST_INIT;
      settle_q <= '0;
      cur_q <= '0;
    end else begin
      case (state_q)
        ST_INIT: begin
          if (settle_q != qdac_pkg::SETTLE_MAX) begin
            settle_q <= settle_q + 2'h1;
          end else if (!rst_low) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (fifo_out_valid && fifo_out_ready) begin
            cur_q <= fifo_out_data;
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: state_q <= ST_IDLE;
        default: state_q <= ST_INIT;
      endcase
    end
  end

  // Mode flags set by commands; soft reset clears them
  always_ff @(posedge clock) begin
    if (!resetn || load_level) begin
      daisy_q <= 1'b0;
      rb_armed_q <= 1'b0;
    end else if (exec && cur_q.cmd == qdac_pkg::CMD_DAISY) begin
      daisy_q <= cur_q.code[0];
    end else if (exec && cur_q.cmd == qdac_pkg::CMD_READBACK) begin
      rb_armed_q <= 1'b1;
    end else if (sync_fall) begin
      rb_armed_q <= 1'b0;
    end
  end

  logic [NCH-1:0] rb_sel_q;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rb_sel_q <= '0;
    end else if (exec && cur_q.cmd == qdac_pkg::CMD_READBACK) begin
      rb_sel_q <= cur_q.chan;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel registers
  logic [NCH-1:0][qdac_pkg::CODE_W-1:0] input_q;
  logic [NCH-1:0][qdac_pkg::CODE_W-1:0] dac_q;
  logic [NCH-1:0] new_q;
  logic sync_mode;
  logic strobe_pulse;
  logic strobe_level;

  assign sync_mode = ctrl_q[qdac_pkg::CTRL_SYNC_BIT];
  // Edge mode: a strobe edge between frames; frame mode only looks at commit
  assign strobe_pulse = load_fall && !frame_q && !rst_low && !sync_mode && state_q != ST_INIT;
  assign strobe_level = load_low && !rst_low;
  assign dac_code = dac_q;

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    logic wr_in;
    logic upd;
    assign wr_in = exec && cur_q.chan[c] && (cur_q.cmd == qdac_pkg::CMD_WR_IN || cur_q.cmd == qdac_pkg::CMD_WR_UPD);
    assign upd = exec && cur_q.chan[c] && (cur_q.cmd == qdac_pkg::CMD_UPD || cur_q.cmd == qdac_pkg::CMD_WR_UPD);

    always_ff @(posedge clock) begin
      if (!resetn) begin
        input_q[c] <= qdac_pkg::ZERO_SCALE;
        dac_q[c] <= qdac_pkg::ZERO_SCALE;
        new_q[c] <= 1'b0;
      end else if (load_level) begin
        input_q[c] <= level;
        dac_q[c] <= level;
        new_q[c] <= 1'b0;
      end else if (wr_in) begin
        input_q[c] <= cur_q.code;
        if (upd || strobe_level) begin
          dac_q[c] <= cur_q.code;
          new_q[c] <= 1'b0;
        end else begin
          new_q[c] <= 1'b1;
        end
      end else if (upd || (strobe_pulse && new_q[c])) begin
        dac_q[c] <= input_q[c];
        new_q[c] <= 1'b0;
      end
    end
  end

  always_comb begin
    rb_word = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (rb_sel_q[c]) begin
        rb_word = input_q[c];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  qdac_pkg::qdac_aphase_t ap_q;
  logic overrun_q;
  logic [31:0] status;
  logic [31:0] rd_mux;
  logic ovr_clear;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ovr_clear = ap_q.valid && ap_q.write && ap_q.addr == qdac_pkg::REG_STATUS && hwdata[qdac_pkg::STAT_OVR_BIT];

  always_comb begin
    status = '0;
    status[qdac_pkg::STAT_INIT_BIT] = state_q != ST_INIT;
    status[qdac_pkg::STAT_RSTPIN_BIT] = rst_low;
    status[qdac_pkg::STAT_OVR_BIT] = overrun_q;
    status[qdac_pkg::STAT_DAISY_BIT] = daisy_q;
    status[qdac_pkg::STAT_RB_BIT] = rb_armed_q;
    status[qdac_pkg::STAT_NEW_LSB +: NCH] = new_q;
    rd_mux = '0;
    if (haddr[7:0] == qdac_pkg::REG_CTRL) begin
      rd_mux = ctrl_q;
    end else if (haddr[7:0] == qdac_pkg::REG_STATUS) begin
      rd_mux = status;
    end
    for (int c = 0; c < NCH; c++) begin
      if (haddr[7:0] == qdac_pkg::REG_DAC_BASE + 8'(4 * c)) begin
        rd_mux = {16'h0000, dac_q[c]};
      end
      if (haddr[7:0] == qdac_pkg::REG_INPUT_BASE + 8'(4 * c)) begin
        rd_mux = {16'h0000, input_q[c]};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ap_q <= '0;
      hrdata <= '0;
    end else if (hready) begin
      ap_q.valid <= hsel && htrans[1];
      ap_q.write <= hwrite;
      ap_q.addr <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl_q <= qdac_pkg::CTRL_RESET;
    end else if (ap_q.valid && ap_q.write && ap_q.addr == qdac_pkg::REG_CTRL) begin
      ctrl_q <= {30'h0, hwdata[1:0]};
    end
  end

  // A lost frame in the same cycle as a clear still sets the flag
  always_ff @(posedge clock) begin
    if (!resetn) begin
      overrun_q <= 1'b0;
    end else if (push && !fifo_in_ready) begin
      overrun_q <= 1'b1;
    end else if (ovr_clear) begin
      overrun_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_shift;
    frame_q && sclk_fall && cnt_q < 5'(qdac_pkg::FRAME_BITS) && !sync_rise
      |=> cnt_q == $past(cnt_q) + 5'h01 && sr_q[0] == $past(pin_q[qdac_pkg::PIN_SIN]);
  endproperty
  a_shift: assert property (p_shift) else $error("bit not shifted in");
  property p_cnt_max;
    cnt_q <= 5'(qdac_pkg::FRAME_BITS);
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("frame took over 24 bits");
  property p_commit;
    sync_rise && frame_q && cnt_q != '0 && fifo_in_ready ##1 state_q == ST_IDLE && !ctrl_q[qdac_pkg::CTRL_HOLD_BIT]
      |=> state_q == ST_EXEC;
  endproperty
  a_commit: assert property (p_commit) else $error("frame not executed at frame end");
  property p_strobe;
    strobe_pulse && new_q[0] && !load_level && !g_chan[0].wr_in |=> dac_q[0] == $past(input_q[0]) && !new_q[0];
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe did not transfer");
  property p_rst_block;
    rst_low && !g_chan[0].wr_in && !g_chan[0].upd && !load_level |=> dac_q[0] == $past(dac_q[0]);
  endproperty
  a_rst_block: assert property (p_rst_block) else $error("strobe honoured during reset");
  property p_rst_level;
    rst_fall |=> dac_q[0] == $past(level) && input_q[0] == $past(level) && dac_q[3] == $past(level);
  endproperty
  a_rst_level: assert property (p_rst_level) else $error("reset level wrong");
  property p_sout;
    sclk_rise && frame_q && daisy_q && !sync_rise |=> serial_out == $past(sr_q[qdac_pkg::FRAME_BITS-1]);
  endproperty
  a_sout: assert property (p_sout) else $error("serial out bit wrong");
  property p_transparent;
    g_chan[1].wr_in && strobe_level && !load_level |=> dac_q[1] == $past(cur_q.code);
  endproperty
  a_transparent: assert property (p_transparent) else $error("held strobe not transparent");
  property p_init_wait;
    state_q == ST_INIT && rst_low |=> state_q == ST_INIT;
  endproperty
  a_init_wait: assert property (p_init_wait) else $error("init left with reset low");
  property p_powerup;
    state_q == ST_INIT ##1 state_q == ST_IDLE |-> dac_q[1] == $past(level) && !new_q[1];
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up level wrong");
  property p_span;
    ##1 span_x2 == $past(pin_q[qdac_pkg::PIN_SPAN]);
  endproperty
  a_span: assert property (p_span) else $error("span select not followed");
  property p_syncmode;
    sync_mode && !g_chan[2].wr_in && !g_chan[2].upd && !load_level |=> dac_q[2] == $past(dac_q[2]);
  endproperty
  a_syncmode: assert property (p_syncmode) else $error("edge honoured in frame mode");

  c_frame: cover property (push && cnt_q == 5'(qdac_pkg::FRAME_BITS));
  c_strobe: cover property (strobe_pulse && |new_q);
  c_readback: cover property (rb_drive_q && sclk_rise);
  c_overrun: cover property (push && !fifo_in_ready);
endmodule

//--- qdac_host_model.sv
// Behavioural serial master that stands in for the host on the link pins.
// Assumes the device samples sclk and data with its own clock.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////
module qdac_host_model (
  // Link pins
  output logic sclk,
  output logic sync_n,
  output logic serial_in,
  // Readback path
  input wire logic serial_out
);
  logic [23:0] rx;

  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    serial_in = 1'b0;
    rx = 24'h000000;
  end

  // Only the low n bits if short, bit n-1 first; sclk idles high so no stray fall
  task automatic send(input logic [23:0] w, input int n);
    // Pins move off the system clock's sampling edge
    #2;
    sync_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      serial_in = w[n-1-i];
      #40 sclk = 1'b0;
      rx = {rx[22:0], serial_out};
      #40 sclk = 1'b1;
    end
    #40 sync_n = 1'b1;
    // Released data line shows the inverse, not a stale copy
    serial_in = ~serial_in;
    #398;
  endtask
endmodule

//--- tb_qdac_top.sv
// Self-checking bench for the quad converter load control.
// Assumes the host model drives the link pins and AHB-Lite reaches registers.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////
module tb_qdac_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic load_strobe_n = 1'b1;
  logic reset_pin_n = 1'b0;
  logic reset_level_select = 1'b1;
  logic span_select = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic sclk, sync_n, serial_in, serial_out, span_x2, hreadyout, hresp;
  logic [31:0] hrdata, rdat;
  logic [qdac_pkg::NCH-1:0][qdac_pkg::CODE_W-1:0] dac_code;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  localparam logic [15:0] MID = qdac_pkg::MID_SCALE;

  always #5 clock = ~clock;

  qdac_top DUT (.clock(clock), .resetn(resetn), .sclk(sclk), .sync_n(sync_n),
    .serial_in(serial_in), .serial_out(serial_out), .load_strobe_n(load_strobe_n),
    .reset_pin_n(reset_pin_n), .reset_level_select(reset_level_select),
    .span_select(span_select), .dac_code(dac_code), .span_x2(span_x2), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

  qdac_host_model host (.sclk(sclk), .sync_n(sync_n), .serial_in(serial_in),
    .serial_out(serial_out));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single word transfer; an idle cycle follows so reads see writes
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rdat = hrdata;
    @(posedge clock);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic pulse();
    load_strobe_n <= 1'b0;
    waitc(4);
    load_strobe_n <= 1'b1;
    waitc(10);
  endtask

  task automatic frame(input logic [3:0] c, input logic [3:0] ch, input logic [15:0] d);
    host.send({c, ch, d}, 24);
    waitc(20);
  endtask

  task automatic t_power();
    waitc(20);
    ahb(1'b0, qdac_pkg::REG_STATUS, 32'h0);
    chk("init_held", 32'h0, {31'h0, rdat[0]});
    reset_pin_n <= 1'b1;
    waitc(20);
    ahb(1'b0, qdac_pkg::REG_STATUS, 32'h0);
    chk("init_done", 32'h1, {31'h0, rdat[0]});
    for (int c = 0; c < 4; c++) begin
      chk("pwr_dac", {16'h0, MID}, {16'h0, dac_code[c]});
      ahb(1'b0, qdac_pkg::REG_INPUT_BASE + 8'(4 * c), 32'h0);
      chk("pwr_in", {16'h0, MID}, rdat);
    end
    ahb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rdat);
    chk("hresp_okay", 32'h0, {31'h0, hresp});
    chk("hready_out", 32'h1, {31'h0, hreadyout});
    $display("test power done");
  endtask

  task automatic t_strobe();
    frame(qdac_pkg::CMD_WR_IN, 4'h1, 16'h1234);
    chk("dac_a_held", {16'h0, MID}, {16'h0, dac_code[0]});
    ahb(1'b0, qdac_pkg::REG_INPUT_BASE, 32'h0);
    chk("in_a", 32'h1234, rdat);
    pulse();
    chk("dac_a", 32'h1234, {16'h0, dac_code[0]});
    chk("dac_b", {16'h0, MID}, {16'h0, dac_code[1]});
    load_strobe_n <= 1'b0;
    frame(qdac_pkg::CMD_WR_IN, 4'h2, 16'h5678);
    chk("dac_b_tr", 32'h5678, {16'h0, dac_code[1]});
    load_strobe_n <= 1'b1;
    $display("test strobe done");
  endtask

  task automatic t_frame_mode();
    ahb(1'b1, qdac_pkg::REG_CTRL, 32'h1);
    frame(qdac_pkg::CMD_WR_IN, 4'h4, 16'h9abc);
    pulse();
    chk("dac_c_held", {16'h0, MID}, {16'h0, dac_code[2]});
    frame(qdac_pkg::CMD_UPD, 4'h4, 16'h0000);
    chk("dac_c", 32'h9abc, {16'h0, dac_code[2]});
    frame(qdac_pkg::CMD_WR_UPD, 4'h8, 16'h0fed);
    chk("dac_d", 32'h0fed, {16'h0, dac_code[3]});
    ahb(1'b1, qdac_pkg::REG_CTRL, 32'h0);
    $display("test frame mode done");
  endtask

  task automatic t_readback();
    frame(qdac_pkg::CMD_READBACK, 4'h1, 16'h0000);
    frame(4'h0, 4'h0, 16'h0000);
    chk("readback", 32'h001234, {8'h0, host.rx});
    // Daisy output repeats the previous word, its MSB included
    frame(qdac_pkg::CMD_DAISY, 4'h0, 16'h0001);
    frame(4'hf, 4'h0, 16'ha5c3);
    chk("daisy_1", {8'h0, qdac_pkg::CMD_DAISY, 20'h00001}, {8'h0, host.rx});
    frame(qdac_pkg::CMD_DAISY, 4'h0, 16'h0000);
    chk("daisy_2", 32'h00f0a5c3, {8'h0, host.rx});
    $display("test readback done");
  endtask

  task automatic t_span();
    span_select <= 1'b1;
    waitc(8);
    chk("span_hi", 32'h1, {31'h0, span_x2});
    span_select <= 1'b0;
    waitc(8);
    chk("span_lo", 32'h0, {31'h0, span_x2});
    $display("test span done");
  endtask

  // Hold stalls the drain, so the seventeenth word has nowhere to go
  task automatic t_fifo();
    ahb(1'b1, qdac_pkg::REG_CTRL, 32'h2);
    repeat (17) host.send(24'h000000, 24);
    ahb(1'b0, qdac_pkg::REG_STATUS, 32'h0);
    chk("overrun", 32'h1, {31'h0, rdat[qdac_pkg::STAT_OVR_BIT]});
    ahb(1'b1, qdac_pkg::REG_STATUS, 32'h4);
    ahb(1'b1, qdac_pkg::REG_CTRL, 32'h0);
    waitc(100);
    ahb(1'b0, qdac_pkg::REG_STATUS, 32'h0);
    chk("ovr_clr", 32'h0, {31'h0, rdat[qdac_pkg::STAT_OVR_BIT]});
    $display("test fifo done");
  endtask

  task automatic t_reset_pin();
    reset_level_select <= 1'b0;
    reset_pin_n <= 1'b0;
    waitc(20);
    for (int c = 0; c < 4; c++) begin
      chk("rst_dac", 32'h0, {16'h0, dac_code[c]});
    end
    ahb(1'b0, qdac_pkg::REG_INPUT_BASE + 8'h4, 32'h0);
    chk("rst_in_b", 32'h0, rdat);
    frame(qdac_pkg::CMD_WR_IN, 4'h1, 16'h4321);
    pulse();
    chk("rst_strobe", 32'h0, {16'h0, dac_code[0]});
    reset_pin_n <= 1'b1;
    waitc(10);
    $display("test reset pin done");
  endtask

  initial begin
    waitc(16);
    resetn <= 1'b1;
    t_power();
    t_strobe();
    t_frame_mode();
    t_readback();
    t_span();
    t_fifo();
    t_reset_pin();
    print_verdict();
  end
endmodule
